// >>> ivc_consts.vh
// Register indices, field layouts and dispatch counts of the interrupt controller
`ifndef IVC_CONSTS_VH
`define IVC_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_POST_G0 8'hDA
`define IDX_POST_G1 8'hDB
`define IDX_POST_G2 8'hDC
`define IDX_SW_CTRL 8'hDE
`define IDX_MASK_G2 8'hDF
`define IDX_MASK_G0 8'hE0
`define IDX_MASK_G1 8'hE1
`define IDX_VECTOR 8'hE2
`define IDX_EVT_STAT 8'hE3
`define IDX_EVT_MASK 8'hE4

// Implemented bits of each group
`define VALID_G0 8'hFF
`define VALID_G1 8'hE0
`define VALID_G2 8'h77
`define VALID_SW_CTRL 8'h80
`define SW_POST_BIT 7

// Reset values
`define RST_BYTE 8'h00
`define RST_EVT 3'h0

// Event status bits
`define EVT_LOST 0
`define EVT_SW_POST 1
`define EVT_VEC_CLR 2

// Core dispatch timing in core cycles
`define DISPATCH_CYCLES 5'h0D
`define JUMP_CYCLES 5'h07

`endif

// >>> irq_prio_encoder.v
// Priority encoder: lowest-numbered pending request wins
`timescale 1ns/1ps
`default_nettype none

module irq_prio_encoder (
  input wire [25:0] pending,
  output reg valid,
  output reg [4:0] prio,
  output reg [7:0] vector
);

  integer i;

  always @*
  begin
    valid = 1'b0;
    prio = 5'h00;
    for (i = 25; i >= 0; i = i - 1)
    begin
      if (pending[i])
      begin
        valid = 1'b1;
        prio = i[4:0];
      end
    end
    vector = {1'b0, prio, 2'b00};
  end

endmodule

`default_nettype wire

// >>> vectored_interrupt_controller.v
// Vectored interrupt controller with APB register access
// Contract
// - Latency: instruction end, 13 dispatch, 7 jump
// - Post/clear reads show posted flags
// - Post disabled: write zero clears, one ignored
// - Post enabled: write one posts, zero ignored
// - Software post enable is bit 7, resets 0
// - Mask zero blocks pending, posting continues
// - Mask one makes posted flag pending
// - Mask bits act independently
// - Port sources post on rising edge
// - Group 0 layout of flags and masks
// - Group 1 layout, low five reserved
// - Group 2 layout, bits 7,3 reserved
// - Vector read gives highest-priority pending vector
// - Any vector write clears all pending
// - Posted flag holds until taken or cleared
// - Lowest priority number wins, vector four times
`timescale 1ns/1ps
`default_nettype none
`include "ivc_consts.vh"

module vectored_interrupt_controller (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [4:0] gpio_port_irq,
  input wire [2:0] ext_line_irq,
  input wire power_fail_event,
  input wire spi_tx_event,
  input wire spi_rx_event,
  input wire sleep_timer_event,
  input wire ms_timer_event,
  input wire interval_timer_event,
  input wire capture_event_zero,
  input wire capture_event_one,
  input wire counter_wrap_event,
  input wire global_irq_enable,
  input wire irq_ack,
  output wire irq_req,
  output wire [7:0] irq_vector,
  output wire dispatch_busy,
  output wire isr_start,
  output wire irq
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_DISP = 3'b010;
  localparam [2:0] S_JUMP = 3'b100;

  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [7:0] pin_s1_r;
  reg [7:0] pin_s2_r;
  reg [7:0] pin_s3_r;
  reg [7:0] post_g0_r;
  reg [7:0] post_g1_r;
  reg [7:0] post_g2_r;
  reg [7:0] mask_g0_r;
  reg [7:0] mask_g1_r;
  reg [7:0] mask_g2_r;
  reg sw_post_en_r;
  reg [2:0] evt_stat_r;
  reg [2:0] evt_mask_r;
  reg irq_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [4:0] cnt_r;
  reg [4:0] cnt_nxt;
  reg irq_req_r;
  reg [7:0] irq_vector_r;
  reg dispatch_busy_r;
  reg isr_start_r;
  reg [31:0] rd_nxt;
  reg map_nxt;

  wire [7:0] pin_rise;
  wire [7:0] hw_g0;
  wire [7:0] hw_g1;
  wire [7:0] hw_g2;
  wire [7:0] pend_g0;
  wire [7:0] pend_g1;
  wire [7:0] pend_g2;
  wire [25:0] pend_prio;
  wire enc_valid;
  wire [4:0] enc_prio;
  wire [7:0] enc_vector;
  wire setup;
  wire wr_acc;
  wire [7:0] widx;
  wire [7:0] wdat;
  wire wr_g0;
  wire wr_g1;
  wire wr_g2;
  wire wr_vec;
  wire take;
  wire [25:0] take_oh;
  wire [7:0] post_g0_nxt;
  wire [7:0] post_g1_nxt;
  wire [7:0] post_g2_nxt;
  wire [2:0] evt_set;
  wire [2:0] evt_clr;
  wire [2:0] evt_stat_nxt;

  // Word index of an aligned address
  function [7:0] word_idx;
    input [9:0] a;
    begin
      word_idx = a[9:2];
    end
  endfunction

  // Group bits onto priority numbers
  function [25:0] to_prio;
    input [7:0] g0;
    input [7:0] g1;
    input [7:0] g2;
    begin
      to_prio = {g0[6], 2'b00, g2[6], g2[5], g2[4], 1'b0, g2[2], g2[1], g2[0],
        g1[7], g1[6], g1[5], 5'h00, g0[5], g0[7], g0[4], g0[3], g0[2], g0[1],
        g0[0], 1'b0};
    end
  endfunction

  // Priority numbers back onto group 0
  function [7:0] prio_g0;
    input [25:0] p;
    begin
      prio_g0 = {p[6], p[25], p[7], p[5], p[4], p[3], p[2], p[1]};
    end
  endfunction

  // Priority numbers back onto group 1
  function [7:0] prio_g1;
    input [25:0] p;
    begin
      prio_g1 = {p[15], p[14], p[13], 5'h00};
    end
  endfunction

  // Priority numbers back onto group 2
  function [7:0] prio_g2;
    input [25:0] p;
    begin
      prio_g2 = {1'b0, p[22], p[21], p[20], 1'b0, p[18], p[17], p[16]};
    end
  endfunction

  // Next posted flags of one group
  function [7:0] post_next;
    input [7:0] cur;
    input [7:0] hw;
    input [7:0] wd;
    input wr;
    input sw;
    input [7:0] vclr;
    input [7:0] aclr;
    input [7:0] valid;
    reg [7:0] sclr;
    reg [7:0] sset;
    begin
      sclr = (wr && !sw) ? ~wd : 8'h00;
      sset = (wr && sw) ? wd : 8'h00;
      post_next = ((cur & ~(sclr | vclr | aclr)) | sset | hw) & valid;
    end
  endfunction

  // Pin inputs: two-flop sync plus edge history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= `RST_BYTE;
      pin_s2_r <= `RST_BYTE;
      pin_s3_r <= `RST_BYTE;
    end
    else
    begin
      pin_s1_r <= {ext_line_irq, gpio_port_irq};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;

  // Hardware posting per group
  assign hw_g0 = {pin_rise[1], sleep_timer_event, pin_rise[6], pin_rise[0], spi_rx_event,
    spi_tx_event, pin_rise[5], power_fail_event};
  assign hw_g1 = {capture_event_zero, interval_timer_event, ms_timer_event, 5'h00};
  assign hw_g2 = {1'b0, pin_rise[4], pin_rise[3], pin_rise[2], 1'b0, pin_rise[7],
    counter_wrap_event, capture_event_one};

  // Pending requests
  assign pend_g0 = post_g0_r & mask_g0_r;
  assign pend_g1 = post_g1_r & mask_g1_r;
  assign pend_g2 = post_g2_r & mask_g2_r;
  assign pend_prio = to_prio(pend_g0, pend_g1, pend_g2);

  irq_prio_encoder irq_prio_encoder_inst (
    .pending(pend_prio),
    .valid(enc_valid),
    .prio(enc_prio),
    .vector(enc_vector)
  );

  // APB decode
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign widx = word_idx(paddr);
  assign wdat = pwdata[7:0];
  assign wr_g0 = wr_acc & (widx == `IDX_POST_G0);
  assign wr_g1 = wr_acc & (widx == `IDX_POST_G1);
  assign wr_g2 = wr_acc & (widx == `IDX_POST_G2);
  assign wr_vec = wr_acc & (widx == `IDX_VECTOR);

  // Core takes the winner
  assign take = (state_r == S_IDLE) & irq_ack & enc_valid & global_irq_enable;
  assign take_oh = take ? (26'h0000001 << enc_prio) : 26'h0000000;

  assign post_g0_nxt = post_next(post_g0_r, hw_g0, wdat, wr_g0, sw_post_en_r,
    wr_vec ? pend_g0 : 8'h00, prio_g0(take_oh), `VALID_G0);
  assign post_g1_nxt = post_next(post_g1_r, hw_g1, wdat, wr_g1, sw_post_en_r,
    wr_vec ? pend_g1 : 8'h00, prio_g1(take_oh), `VALID_G1);
  assign post_g2_nxt = post_next(post_g2_r, hw_g2, wdat, wr_g2, sw_post_en_r,
    wr_vec ? pend_g2 : 8'h00, prio_g2(take_oh), `VALID_G2);

  // Event status: set wins over write-one clear
  assign evt_set[`EVT_LOST] = |((hw_g0 & post_g0_r) | (hw_g1 & post_g1_r) | (hw_g2 & post_g2_r));
  assign evt_set[`EVT_SW_POST] = sw_post_en_r & (wr_g0 | wr_g1 | wr_g2) & (|wdat);
  assign evt_set[`EVT_VEC_CLR] = wr_vec;
  assign evt_clr = (wr_acc && widx == `IDX_EVT_STAT) ? wdat[2:0] : 3'h0;
  assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;

  // Flags and control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      post_g0_r <= `RST_BYTE;
      post_g1_r <= `RST_BYTE;
      post_g2_r <= `RST_BYTE;
      mask_g0_r <= `RST_BYTE;
      mask_g1_r <= `RST_BYTE;
      mask_g2_r <= `RST_BYTE;
      sw_post_en_r <= 1'b0;
      evt_stat_r <= `RST_EVT;
      evt_mask_r <= `RST_EVT;
      irq_r <= 1'b0;
    end
    else
    begin
      post_g0_r <= post_g0_nxt;
      post_g1_r <= post_g1_nxt;
      post_g2_r <= post_g2_nxt;
      evt_stat_r <= evt_stat_nxt;
      irq_r <= |(evt_stat_nxt & evt_mask_r);
      if (wr_acc)
      begin
        case (widx)
          `IDX_MASK_G0:
          begin
            mask_g0_r <= wdat & `VALID_G0;
          end
          `IDX_MASK_G1:
          begin
            mask_g1_r <= wdat & `VALID_G1;
          end
          `IDX_MASK_G2:
          begin
            mask_g2_r <= wdat & `VALID_G2;
          end
          `IDX_SW_CTRL:
          begin
            sw_post_en_r <= wdat[`SW_POST_BIT];
          end
          `IDX_EVT_MASK:
          begin
            evt_mask_r <= wdat[2:0];
          end
          default:
          begin
            sw_post_en_r <= sw_post_en_r;
          end
        endcase
      end
    end
  end

  // Read mux and map check
  always @*
  begin
    rd_nxt = 32'h00000000;
    map_nxt = (paddr[1:0] == 2'b00);
    case (widx)
      `IDX_POST_G0: rd_nxt[7:0] = post_g0_r;
      `IDX_POST_G1: rd_nxt[7:0] = post_g1_r;
      `IDX_POST_G2: rd_nxt[7:0] = post_g2_r;
      `IDX_SW_CTRL: rd_nxt[7:0] = {sw_post_en_r, 7'h00};
      `IDX_MASK_G0: rd_nxt[7:0] = mask_g0_r;
      `IDX_MASK_G1: rd_nxt[7:0] = mask_g1_r;
      `IDX_MASK_G2: rd_nxt[7:0] = mask_g2_r;
      `IDX_VECTOR: rd_nxt[7:0] = enc_vector;
      `IDX_EVT_STAT: rd_nxt[2:0] = evt_stat_r;
      `IDX_EVT_MASK: rd_nxt[2:0] = evt_mask_r;
      default: map_nxt = 1'b0;
    endcase
    if (!map_nxt)
    begin
      rd_nxt = 32'h00000000;
    end
  end

  // APB answer: one access cycle, no waits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      if (setup)
      begin
        prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr_r <= ~map_nxt;
      end
      else if (!(psel && penable))
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Dispatch sequencer next state
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_IDLE:
      begin
        if (take)
        begin
          state_nxt = S_DISP;
          cnt_nxt = `DISPATCH_CYCLES - 5'h01;
        end
      end
      S_DISP:
      begin
        if (cnt_r == 5'h00)
        begin
          state_nxt = S_JUMP;
          cnt_nxt = `JUMP_CYCLES - 5'h01;
        end
        else
        begin
          cnt_nxt = cnt_r - 5'h01;
        end
      end
      S_JUMP:
      begin
        if (cnt_r == 5'h00)
        begin
          state_nxt = S_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 5'h01;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
        cnt_nxt = 5'h00;
      end
    endcase
  end

  // Dispatch sequencer and core outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
      cnt_r <= 5'h00;
      irq_req_r <= 1'b0;
      irq_vector_r <= `RST_BYTE;
      dispatch_busy_r <= 1'b0;
      isr_start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dispatch_busy_r <= (state_nxt != S_IDLE);
      irq_req_r <= enc_valid & global_irq_enable & (state_nxt == S_IDLE) & ~take;
      isr_start_r <= (state_r == S_JUMP) & (cnt_r == 5'h00);
      if (take)
      begin
        irq_vector_r <= enc_vector;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign irq_vector = irq_vector_r;
  assign dispatch_busy = dispatch_busy_r;
  assign isr_start = isr_start_r;
  assign irq = irq_r;

endmodule

`default_nettype wire

// >>> ivc_checker_asserts.sv
// Port checker for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module ivc_checker (
  input wire pclk,
  input wire presetn,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire global_irq_enable,
  input wire irq_ack,
  input wire irq_req,
  input wire [7:0] irq_vector,
  input wire dispatch_busy,
  input wire isr_start
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite && !pslverr;
  property p_latency;
    $rose(dispatch_busy) |-> ##20 isr_start;
  endproperty
  a_latency: assert property (p_latency) else $error("dispatch length wrong");
  property p_isr_end;
    isr_start |=> !isr_start && !dispatch_busy;
  endproperty
  a_isr_end: assert property (p_isr_end) else $error("dispatch end wrong");
  property p_no_req;
    dispatch_busy |-> !irq_req;
  endproperty
  a_no_req: assert property (p_no_req) else $error("request during dispatch");
  property p_gie_gate;
    irq_ack && !global_irq_enable && !dispatch_busy |=> !dispatch_busy [*3];
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("take without enable");
  property p_take_vec;
    $rose(dispatch_busy) |-> irq_vector[1:0] == 2'h0 && irq_vector inside {[8'h04:8'h64]};
  endproperty
  a_take_vec: assert property (p_take_vec) else $error("taken vector bad");
  property p_vec_read;
    rd_ok && paddr == 10'h388 |-> prdata[1:0] == 2'h0 && prdata <= 32'h64;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("vector read bad");
  property p_upper;
    rd_ok |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_grp1;
    rd_ok && (paddr == 10'h36C || paddr == 10'h384) |-> prdata[4:0] == 5'h00;
  endproperty
  a_grp1: assert property (p_grp1) else $error("group 1 reserved set");
  property p_grp2;
    rd_ok && (paddr == 10'h370 || paddr == 10'h37C) |-> !prdata[7] && !prdata[3];
  endproperty
  a_grp2: assert property (p_grp2) else $error("group 2 reserved set");
  property p_swc;
    rd_ok && paddr == 10'h378 |-> prdata[6:0] == 7'h00;
  endproperty
  a_swc: assert property (p_swc) else $error("control reserved set");
endmodule
bind vectored_interrupt_controller ivc_checker ivc_checker_inst (.pclk(pclk),
  .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .dispatch_busy(dispatch_busy),
  .isr_start(isr_start));
`default_nettype wire

// >>> ivc_core_model.sv
// Core model that takes vectored interrupts
`timescale 1ns/1ps
`default_nettype none
module ivc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic poke,
  input wire logic [1:0] slow,
  input wire logic irq_req,
  input wire logic isr_start,
  output logic global_irq_enable,
  output logic irq_ack
);
  logic busy_r;
  logic [1:0] wait_r;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      global_irq_enable <= 1'b0;
      irq_ack <= 1'b0;
      busy_r <= 1'b0;
      wait_r <= 2'h0;
    end
    else
    begin
      irq_ack <= poke;
      global_irq_enable <= run && !busy_r && !irq_ack;
      if (irq_ack)
        busy_r <= 1'b1;
      else if (isr_start)
        busy_r <= 1'b0;
      if (irq_req && global_irq_enable && !irq_ack && !busy_r)
      begin
        wait_r <= (wait_r == slow) ? 2'h0 : wait_r + 2'h1;
        if (wait_r == slow)
          irq_ack <= 1'b1;
      end
    end
endmodule
`default_nettype wire

// >>> vectored_interrupt_controller_tb_top.sv
// Testbench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb_top;
  localparam logic [9:0] PA [3] = '{10'h368, 10'h36C, 10'h370};
  localparam logic [9:0] MA [3] = '{10'h380, 10'h384, 10'h37C};
  localparam logic [7:0] VA [3] = '{8'hFF, 8'hE0, 8'h77};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s, run, poke;
  logic irq_req, dispatch_busy, isr_start, irq, irq_en, ack;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] ev, e;
  logic [7:0] pin, irq_vector, d, g[3], m[3], x[3];
  logic [1:0] slow;
  logic [25:0] p;
  int fail_count, checks, k;
  vectored_interrupt_controller vectored_interrupt_controller_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_port_irq(pin[4:0]), .ext_line_irq(pin[7:5]), .power_fail_event(ev[0]),
    .spi_tx_event(ev[1]), .spi_rx_event(ev[2]), .sleep_timer_event(ev[3]),
    .ms_timer_event(ev[4]), .interval_timer_event(ev[5]), .capture_event_zero(ev[6]),
    .capture_event_one(ev[7]), .counter_wrap_event(ev[8]), .global_irq_enable(irq_en),
    .irq_ack(ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .dispatch_busy(dispatch_busy), .isr_start(isr_start), .irq(irq));
  ivc_core_model ivc_core_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
    .poke(poke), .slow(slow), .irq_req(irq_req), .isr_start(isr_start),
    .global_irq_enable(irq_en), .irq_ack(ack));
  task automatic chk(input string n, input logic [31:0] xe, input logic [31:0] y);
    checks++;
    if (xe !== y)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, xe, y);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] dd,
    input logic [8:0] hit);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    ev <= hit;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      $display("unexpected pready exp 1 got %b", pready);
    end
    q = prdata;
    s = pslverr;
    ev <= 9'h000;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [25:0] pend();
    logic [7:0] a, b, c;
    a = g[0] & m[0];
    b = g[1] & m[1];
    c = g[2] & m[2];
    return {a[6], 2'h0, c[6:4], 1'b0, c[2:0], b[7:5], 5'h00, a[5], a[7], a[4:0], 1'b0};
  endfunction
  function automatic logic [7:0] low(input logic [25:0] v);
    for (int j = 0; j < 26; j++)
      if (v[j])
        return 8'(4 * j);
    return 8'h00;
  endfunction
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    fail_count++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, run, poke, paddr, pwdata, ev, pin, slow} = '0;
    g = '{8'h00, 8'h00, 8'h00};
    void'($urandom(82807));
    tick(8);
    presetn <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      bus(0, PA[j], 0, 0);
      chk("post reset", 0, q);
      bus(0, MA[j], 0, 0);
      chk("mask reset", 0, q);
    end
    bus(0, 10'h378, 0, 0);
    chk("control reset", 0, q);
    bus(0, 10'h3FC, 0, 0);
    chk("refused", 1, s);
    for (int n = 0; n < 60; n++)
    begin
      k = $urandom_range(2);
      d = 8'($urandom);
      bus(1, 10'h378, {24'h0, n[0], 7'h7F}, 0);
      bus(1, PA[k], {24'h0, d}, 0);
      g[k] = n[0] ? g[k] | (d & VA[k]) : g[k] & d;
      bus(0, PA[k], 0, 0);
      chk("post", {24'h0, g[k]}, q);
    end
    repeat (20)
    begin
      for (int j = 0; j < 3; j++)
      begin
        d = 8'($urandom);
        m[j] = d & VA[j];
        bus(1, 10'h378, 0, 0);
        bus(1, PA[j], 0, 0);
        bus(1, 10'h378, 32'h80, 0);
        bus(1, MA[j], {24'h0, d}, 0);
        d = 8'($urandom);
        g[j] = d & VA[j];
        bus(1, PA[j], {24'h0, d}, 0);
        bus(0, MA[j], 0, 0);
        chk("mask", {24'h0, m[j]}, q);
      end
      bus(0, 10'h388, 0, 0);
      chk("vector", {24'h0, low(pend())}, q);
      bus(1, 10'h388, $urandom, 0);
      for (int j = 0; j < 3; j++)
      begin
        g[j] = g[j] & ~m[j];
        bus(0, PA[j], 0, 0);
        chk("kept", {24'h0, g[j]}, q);
      end
    end
    bus(1, 10'h378, 0, 0);
    repeat (10)
    begin
      e = 9'($urandom);
      d = 8'($urandom);
      for (int j = 0; j < 3; j++)
        bus(1, PA[j], 0, 0);
      pin <= d;
      bus(1, PA[0], 0, e);
      tick(4);
      x = '{{d[1], e[3], d[6], d[0], e[2], e[1], d[5], e[0]}, {e[6:4], 5'h00},
        {1'b0, d[4:2], 1'b0, d[7], e[8:7]}};
      for (int j = 0; j < 3; j++)
      begin
        bus(0, PA[j], 0, 0);
        chk("hw post", {24'h0, x[j]}, q);
        bus(1, PA[j], 0, 0);
        tick(4);
        bus(0, PA[j], 0, 0);
        chk("level", 0, q);
      end
      pin <= 8'h00;
      tick(4);
    end
    for (int j = 0; j < 3; j++)
    begin
      m[j] = VA[j];
      bus(1, MA[j], 32'hFF, 0);
    end
    bus(1, 10'h378, 32'h80, 0);
    repeat (6)
    begin
      for (int j = 0; j < 3; j++)
      begin
        g[j] = 8'($urandom) & VA[j];
        bus(1, PA[j], {24'h0, g[j]}, 0);
      end
      p = pend();
      slow <= 2'($urandom);
      run <= 1'b1;
      while (p != 0)
      begin
        k = 0;
        while (isr_start !== 1'b1 && k < 200)
        begin
          @(posedge pclk);
          k++;
        end
        chk("isr start", 1, isr_start);
        chk("taken", {24'h0, low(p)}, {24'h0, irq_vector});
        p[low(p) / 4] = 1'b0;
        @(posedge pclk);
      end
      run <= 1'b0;
      tick(3);
    end
    bus(1, PA[0], 32'h01, 0);
    poke <= 1'b1;
    tick(1);
    poke <= 1'b0;
    tick(4);
    chk("refused take", 0, dispatch_busy);
    bus(1, 10'h390, 32'h02, 0);
    bus(1, 10'h38C, 32'h07, 0);
    bus(1, PA[1], 32'h20, 0);
    for (int n = 0; n < 4; n++)
    begin
      tick(3);
      chk("irq", n[0] ? 0 : 1, irq);
      bus(1, n == 2 ? 10'h38C : 10'h390, (n[0] || n == 2) ? 32'h02 : 32'h00, 0);
    end
    tick(3);
    chk("irq", 0, irq);
    results();
  end
endmodule
`default_nettype wire
